// ---- hdl/dfr_pkg.sv ----
// Package for the disc fault code reporter: fault codes, classes, timing.
// Assumes a single 125 MHz clock domain.
package dfr_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 125;
   localparam int XFER_LIMIT_MS = 10;
   localparam int XFER_LIMIT_CYC = XFER_LIMIT_MS * 1000 * CLK_MHZ;
   localparam int CMD_LIMIT_CYC = 1000000;
   localparam int RETRY_LIMIT = 8;

   // ==========================================================
   // Fault events, one bit each, index gives priority (lowest wins)
   localparam int NUM_EVT = 48;
   localparam int EV_HDR_TMO = 0;
   localparam int EV_FATAL_RD = 1;
   localparam int EV_FATAL_WR = 2;
   localparam int EV_RX_FMT = 3;
   localparam int EV_RX_VFY = 4;
   localparam int EV_RX_HDR = 5;
   localparam int EV_SPR_HDR_TMO = 6;
   localparam int EV_SPR_DEALLOC_TMO = 7;
   localparam int EV_SPR_FLAG_TMO = 8;
   localparam int EV_SPR_PRE_TMO = 9;
   localparam int EV_RX_FMT_TMO = 10;
   localparam int EV_RX_HDR_TMO = 11;
   localparam int EV_RX_VFY_TMO = 12;
   localparam int EV_DEFECT_ED = 13;
   localparam int EV_SPR_FLAG_ERR = 14;
   localparam int EV_SPR_TRK_ERR = 15;
   localparam int EV_SPR_DEALLOC_ERR = 16;
   localparam int EV_FIFO_RD = 17;
   localparam int EV_FIFO_WR = 18;
   localparam int EV_HDR_MATCH = 19;
   localparam int EV_CORR_SPUR = 20;
   localparam int EV_LATE_SPUR = 21;
   localparam int EV_IF_FATAL_RD = 22;
   localparam int EV_IF_FATAL_WR = 23;
   localparam int EV_LOG_UNREC = 24;
   localparam int EV_LOG_NOVALID = 25;
   localparam int EV_ATN_FLAG = 26;
   localparam int EV_ATN_PRE = 27;
   localparam int EV_ATN_HDR = 28;
   localparam int EV_ATN_DEALLOC = 29;
   localparam int EV_ATN_LOCAL_RD = 30;
   localparam int EV_LSEEK_TMO = 31;
   localparam int EV_PSEEK_TMO = 32;
   localparam int EV_LSEEK_DEFECT = 33;
   localparam int EV_NOINT_DEFECT = 34;
   localparam int EV_NOINT_FULL = 35;
   localparam int EV_ERT_OVF = 36;
   localparam int EV_LOG_PWRUP = 37;
   localparam int EV_ECC_TMO = 38;
   localparam int EV_COMM_TMO = 39;
   localparam int EV_XFER_SET = 40;
   localparam int EV_XFER_CLR = 41;
   localparam int EV_CMD_TMO = 42;
   localparam int EV_RETRY_OUT = 43;
   localparam int EV_STAT_FAIL = 44;
   localparam int EV_SAVE_CTL = 45;
   localparam int EV_SAVE_IF = 46;
   localparam int EV_SPARE = 47;

   // ==========================================================
   // Code for each event, same order as the indices above
   localparam logic [7:0] CODE_TABLE [NUM_EVT] = '{
      8'h60, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h68, 8'h69,
      8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h71, 8'h72, 8'h73,
      8'h74, 8'h81, 8'h82, 8'h83, 8'h86, 8'h87, 8'h91, 8'h92,
      8'h9E, 8'h9F, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hAA, 8'hB0,
      8'hB1, 8'hB2, 8'hBE, 8'hBF, 8'hC0, 8'hC1, 8'hC5, 8'hCB,
      8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD5, 8'h67, 8'h9D, 8'h00};

   // Layout classes of the parameter bytes
   typedef enum logic [2:0] {
      CLS_CTL = 3'h1,
      CLS_IF = 3'h2,
      CLS_PLAIN = 3'h4
   } dfr_class_t;

   // First event of the interface class and of the plain class
   localparam int FIRST_IF = 22;
   localparam int FIRST_PLAIN = 31;

   // Reset values of the held status
   localparam logic [7:0] BYTE_RST = 8'h00;

   // Register map
   localparam logic [3:0] ADR_CODE = 4'h0;
   localparam logic [3:0] ADR_BYTE8 = 4'h1;
   localparam logic [3:0] ADR_BYTE9 = 4'h2;
   localparam logic [3:0] ADR_BYTE10 = 4'h3;
   localparam logic [3:0] ADR_STATUS = 4'h4;
   localparam logic [3:0] ADR_LOG = 4'h5;
   localparam logic [3:0] ADR_ACK = 4'h6;

endpackage : dfr_pkg

// ---- hdl/dfr_reporter.sv ----
// Fault classifier, status byte holder and drive handshake supervisor.
// Assumes synchronous inputs on one clock, and a host that reads status
// over the plain register port.
//
// Notes on behaviour
// - Controller faults: code, controller status, error bytes
// - Header read timeout reports 60
// - Controller fatal fault: 62 read, 63 write
// - Retries out: 64/65/66, after timeout 6C/6E/6D
// - Codes 67, 9D never touch status
// - Sparing timeouts report 68 to 6B
// - Defect list error 71, sparing errors 72-74
// - FIFO loss: 81 read, 82 write
// - Interface faults: code, compressed status, vendor byte
// - Attention in local read: 8'hAA, no retry
// - Attention during sparing reports A0 to A3
// - Logs unreadable 9E, no valid copy 9F
// - Plain unit faults: bytes eight to ten zero
// - Seek timeouts B0, B1; defective track B2
// - Acknowledge 10 ms limits, else D0 or D1
// - Command complete timeout D2, retries out D3
// - Interface status request failure reports D5
// - Test log overflow C0, log read C1
// - ECC cycle timeout C5, comm timeout CB
// - Header-match failure 83, missed seek flag if status bit 0 (head error) clear
// - Spurious correction 86, late interlock 87
// - Missing controller interrupt BE, BF
module dfr_reporter
   import dfr_pkg::*;
#(
   parameter int XFER_CYC = XFER_LIMIT_CYC,
   parameter int CMD_CYC = CMD_LIMIT_CYC,
   parameter int RETRIES = RETRY_LIMIT
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [NUM_EVT-1:0] faultEvt,
   input wire logic [7:0] ctlStatus,
   input wire logic [7:0] ctlError,
   input wire logic [7:0] ifStatus,
   input wire logic [7:0] vendorStatus,
   input wire logic xferReq,
   input wire logic xferAck,
   input wire logic cmdSent,
   input wire logic cmdComplete,
   input wire logic cmdRetry,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   output logic faultValid,
   output logic logValid,
   output logic [7:0] logCode,
   output logic [7:0] logStatus,
   output logic [7:0] logExtra,
   output logic noRetry,
   output logic missedSeek
);

   // ==========================================================
   // Drive handshake supervision
   logic [31:0] xferCnt_q;
   logic [31:0] cmdCnt_q;
   logic cmdBusy_q;
   logic [7:0] retryCnt_q;
   logic xferSetTmo, xferClrTmo, cmdTmo, retryOut;
   logic ackPending;

   // Waiting means request and acknowledge disagree
   assign ackPending = xferReq ^ xferAck;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         xferCnt_q <= 32'h0;
      end else if (!ackPending) begin
         xferCnt_q <= 32'h0;
      end else if (xferCnt_q != 32'(XFER_CYC)) begin
         xferCnt_q <= xferCnt_q + 32'h1;
      end
   end

   // One pulse when the limit is first reached
   assign xferSetTmo = ackPending && xferReq && xferCnt_q == 32'(XFER_CYC - 1);
   assign xferClrTmo = ackPending && !xferReq && xferCnt_q == 32'(XFER_CYC - 1);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmdBusy_q <= 1'b0;
         cmdCnt_q <= 32'h0;
      end else if (cmdSent) begin
         cmdBusy_q <= 1'b1;
         cmdCnt_q <= 32'h0;
      end else if (cmdComplete || cmdTmo) begin
         cmdBusy_q <= 1'b0;
      end else if (cmdBusy_q) begin
         cmdCnt_q <= cmdCnt_q + 32'h1;
      end
   end

   assign cmdTmo = cmdBusy_q && !cmdComplete && cmdCnt_q == 32'(CMD_CYC - 1);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         retryCnt_q <= 8'h00;
      end else if (cmdComplete) begin
         retryCnt_q <= 8'h00;
      end else if (cmdRetry && retryCnt_q != 8'hFF) begin
         retryCnt_q <= retryCnt_q + 8'h01;
      end
   end

   assign retryOut = cmdRetry && retryCnt_q == 8'(RETRIES);

   // ==========================================================
   // Event merge and priority pick
   logic [NUM_EVT-1:0] evt;
   logic evtAny;
   logic [5:0] evtIdx;

   always_comb begin
      evt = faultEvt;
      evt[EV_XFER_SET] = faultEvt[EV_XFER_SET] | xferSetTmo;
      evt[EV_XFER_CLR] = faultEvt[EV_XFER_CLR] | xferClrTmo;
      evt[EV_CMD_TMO] = faultEvt[EV_CMD_TMO] | cmdTmo;
      evt[EV_RETRY_OUT] = faultEvt[EV_RETRY_OUT] | retryOut;
      evt[EV_SAVE_CTL] = 1'b0;
      evt[EV_SAVE_IF] = 1'b0;
      evt[EV_SPARE] = 1'b0;
   end

   always_comb begin
      evtAny = 1'b0;
      evtIdx = 6'h00;
      for (int i = NUM_EVT - 1; i >= 0; i--) begin
         if (evt[i]) begin
            evtAny = 1'b1;
            evtIdx = 6'(i);
         end
      end
   end

   // ==========================================================
   // Classify and form the parameter bytes
   dfr_class_t cls;
   logic [7:0] codeD, byte8D, byte9D;

   always_comb begin
      if (int'(evtIdx) < FIRST_IF) begin
         cls = CLS_CTL;
      end else if (int'(evtIdx) < FIRST_PLAIN) begin
         cls = CLS_IF;
      end else begin
         cls = CLS_PLAIN;
      end
   end

   // Table lookup
   assign codeD = CODE_TABLE[evtIdx];

   always_comb begin
      case (cls)
         CLS_CTL: begin
            byte8D = ctlStatus;
            byte9D = ctlError;
         end
         CLS_IF: begin
            byte8D = ifStatus;
            byte9D = vendorStatus;
         end
         default: begin
            byte8D = BYTE_RST;
            byte9D = BYTE_RST;
         end
      endcase
   end

   // ==========================================================
   // Held status bytes, locked until the host acknowledges
   logic valid_q;
   logic [7:0] code_q, byte8_q, byte9_q;
   logic missed_q;
   logic hostAck;
   logic capture;

   // Write of 1 to the acknowledge register frees the holder
   assign hostAck = regWr && regAddr == ADR_ACK && regWrData[0];
   // A new fault in the ack cycle is taken, not lost
   assign capture = evtAny && (!valid_q || hostAck);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         valid_q <= 1'b0;
      end else if (capture) begin
         valid_q <= 1'b1;
      end else if (hostAck) begin
         valid_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         code_q <= BYTE_RST;
         byte8_q <= BYTE_RST;
         byte9_q <= BYTE_RST;
         missed_q <= 1'b0;
      end else if (capture) begin
         code_q <= codeD;
         byte8_q <= byte8D;
         byte9_q <= byte9D;
         // Head error flag assumed in status bit 0
         missed_q <= evtIdx == 6'(EV_HDR_MATCH) && !ctlStatus[0];
      end
   end

   // ==========================================================
   // Fault log entry, one cycle per accepted fault
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         logValid <= 1'b0;
         logCode <= BYTE_RST;
         logStatus <= BYTE_RST;
         logExtra <= BYTE_RST;
         noRetry <= 1'b0;
      end else begin
         // Logs every fault except the save markers, even while the status holder is locked
         logValid <= evtAny;
         logCode <= codeD;
         logStatus <= byte8D;
         logExtra <= cls == CLS_PLAIN ? BYTE_RST : byte9D;
         noRetry <= evt[EV_ATN_LOCAL_RD];
      end
   end

   // ==========================================================
   // Register read port, data one cycle after the strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else if (!regRd) begin
         regRdData <= 8'h00;
      end else if (regAddr == ADR_CODE) begin
         regRdData <= code_q;
      end else if (regAddr == ADR_BYTE8) begin
         regRdData <= byte8_q;
      end else if (regAddr == ADR_BYTE9) begin
         regRdData <= byte9_q;
      end else if (regAddr == ADR_BYTE10) begin
         regRdData <= BYTE_RST;
      end else if (regAddr == ADR_STATUS) begin
         regRdData <= {5'h00, cmdBusy_q, missed_q, valid_q};
      end else if (regAddr == ADR_LOG) begin
         regRdData <= retryCnt_q;
      end else begin
         regRdData <= 8'h00;
      end
   end

   assign faultValid = valid_q;
   assign missedSeek = missed_q;

endmodule : dfr_reporter

// ---- sim/dfr_props.sv ----
// Port checker for the fault reporter.
// Assumes one clock domain and a bind onto the reporter.
module dfr_props
   import dfr_pkg::*;
#(
   parameter int XFER_CYC = 20,
   parameter int CMD_CYC = 30,
   parameter int RETRIES = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [NUM_EVT-1:0] faultEvt,
   input wire logic [7:0] ctlStatus,
   input wire logic [7:0] ctlError,
   input wire logic [7:0] ifStatus,
   input wire logic [7:0] vendorStatus,
   input wire logic xferReq,
   input wire logic xferAck,
   input wire logic cmdSent,
   input wire logic cmdComplete,
   input wire logic cmdRetry,
   input wire logic regWr,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic faultValid,
   input wire logic logValid,
   input wire logic [7:0] logCode,
   input wire logic [7:0] logStatus,
   input wire logic [7:0] logExtra,
   input wire logic noRetry,
   input wire logic missedSeek
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ==========================================================
   // Wait counters, checked a little early to allow for latency
   int misQ;
   int cmdQ;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) misQ <= 0;
      else if (xferReq == xferAck) misQ <= 0;
      else misQ <= misQ + 1;
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) cmdQ <= 0;
      else if (cmdSent) cmdQ <= 1;
      else if (cmdComplete) cmdQ <= 0;
      else if (cmdQ != 0) cmdQ <= cmdQ + 1;
   end
   // ==========================================================
   // Assertions
   a_ctl_bytes: assert property (faultEvt[0] |=> logValid && logCode == 8'h60 &&
      logStatus == $past(ctlStatus) && logExtra == $past(ctlError)) else $error("ctl log bad");
   a_if_bytes: assert property (faultEvt[22] && faultEvt[21:0] == '0 |=> logCode == 8'h91 &&
      logStatus == $past(ifStatus) && logExtra == $past(vendorStatus)) else $error("if log bad");
   a_plain_zero: assert property (faultEvt[31] && faultEvt[30:0] == '0 |=>
      logCode == 8'hB0 && logStatus == 8'h00 && logExtra == 8'h00) else $error("plain log bad");
   // Handshake idle and no retry, so only the save markers could set the holder
   a_save_silent: assert property (faultEvt[46:45] != '0 && faultEvt[44:0] == '0 &&
      !cmdRetry && xferReq == xferAck && cmdQ == 0 && !faultValid |=> !faultValid)
      else $error("fault set with no event");
   a_hold_fault: assert property (faultValid && !(regWr && regAddr == ADR_ACK && regWrData[0])
      |=> faultValid) else $error("fault dropped early");
   a_local_atn: assert property (faultEvt[30] && faultEvt[29:0] == '0 |=>
      noRetry && logCode == 8'hAA) else $error("attention not fatal");
   a_miss_seek: assert property (faultEvt[19] && faultEvt[18:0] == '0 && !faultValid &&
      !ctlStatus[0] |=> missedSeek) else $error("missed seek not flagged");
   a_ack_set: assert property (misQ == XFER_CYC - 2 && xferReq |-> ##[0:6]
      (logValid && logCode == 8'hD0)) else $error("no set timeout");
   a_ack_clr: assert property (misQ == XFER_CYC - 2 && !xferReq |-> ##[0:6]
      (logValid && logCode == 8'hD1)) else $error("no clear timeout");
   a_cmd_late: assert property (cmdQ == CMD_CYC - 2 |-> ##[0:6]
      (logValid && logCode == 8'hD2)) else $error("no command timeout");
endmodule : dfr_props

bind dfr_reporter dfr_props #(.XFER_CYC(XFER_CYC), .CMD_CYC(CMD_CYC), .RETRIES(RETRIES)) u_props (
   .clock(clock), .rst(rst), .faultEvt(faultEvt), .ctlStatus(ctlStatus), .ctlError(ctlError),
   .ifStatus(ifStatus), .vendorStatus(vendorStatus), .xferReq(xferReq), .xferAck(xferAck),
   .cmdSent(cmdSent), .cmdComplete(cmdComplete), .regWr(regWr), .regAddr(regAddr),
   .cmdRetry(cmdRetry),
   .regWrData(regWrData), .faultValid(faultValid), .logValid(logValid), .logCode(logCode),
   .logStatus(logStatus), .logExtra(logExtra), .noRetry(noRetry), .missedSeek(missedSeek));

// ---- sim/dfr_drive_model.sv ----
// Drive mechanism model: transfer acknowledge and command complete.
// Assumes the reporter's clock; slow makes it miss every time limit.
module dfr_drive_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic xferReq,
   input wire logic cmdSent,
   input wire logic slow,
   output logic xferAck,
   output logic cmdComplete
);
   timeunit 1ns;
   timeprecision 1ps;
   int ackCnt;
   int cmdCnt;
   // ==========================================================
   // Acknowledge follows request, late by 40 when slow
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         xferAck <= 1'b0;
         ackCnt <= 0;
      end else if (xferAck == xferReq) begin
         ackCnt <= 0;
      end else if (ackCnt >= (slow ? 40 : 2)) begin
         xferAck <= xferReq;
         ackCnt <= 0;
      end else begin
         ackCnt <= ackCnt + 1;
      end
   end
   // ==========================================================
   // Complete pulse 3 cycles after a command; a slow drive never answers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmdComplete <= 1'b0;
         cmdCnt <= 0;
      end else begin
         cmdComplete <= (cmdCnt == 3);
         if (cmdSent) cmdCnt <= slow ? 0 : 1;
         else if (cmdCnt != 0) cmdCnt <= (cmdCnt == 4) ? 0 : cmdCnt + 1;
      end
   end
endmodule : dfr_drive_model

// ---- sim/dfr_reporter_test.sv ----
// Self-checking bench for the fault reporter.
// Assumes the drive model on the handshake and shortened time limits.
module dfr_reporter_test;
   import dfr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int XC = 20;
   localparam int CC = 30;
   localparam int RT = 2;
   localparam logic [7:0] EXP [45] = '{8'h60, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h68, 8'h69,
      8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h71, 8'h72, 8'h73, 8'h74, 8'h81, 8'h82, 8'h83, 8'h86,
      8'h87, 8'h91, 8'h92, 8'h9E, 8'h9F, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hAA, 8'hB0, 8'hB1, 8'hB2,
      8'hBE, 8'hBF, 8'hC0, 8'hC1, 8'hC5, 8'hCB, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD5};
   logic clock, rst, xferReq, xferAck, cmdSent, cmdComplete, cmdRetry, regWr, regRd, slow;
   logic faultValid, logValid, noRetry, missedSeek;
   logic [NUM_EVT-1:0] faultEvt;
   logic [7:0] ctlStatus, ctlError, ifStatus, vendorStatus, regWrData, regRdData;
   logic [7:0] logCode, logStatus, logExtra;
   logic [3:0] regAddr;
   int n_fail, check_count, cyc;

   dfr_reporter #(.XFER_CYC(XC), .CMD_CYC(CC), .RETRIES(RT)) DUT (.clock(clock), .rst(rst),
      .faultEvt(faultEvt), .ctlStatus(ctlStatus), .ctlError(ctlError), .ifStatus(ifStatus),
      .vendorStatus(vendorStatus), .xferReq(xferReq), .xferAck(xferAck), .cmdSent(cmdSent),
      .cmdComplete(cmdComplete), .cmdRetry(cmdRetry), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .faultValid(faultValid),
      .logValid(logValid), .logCode(logCode), .logStatus(logStatus), .logExtra(logExtra),
      .noRetry(noRetry), .missedSeek(missedSeek));
   dfr_drive_model drive (.clock(clock), .rst(rst), .xferReq(xferReq), .cmdSent(cmdSent),
      .slow(slow), .xferAck(xferAck), .cmdComplete(cmdComplete));

   // ==========================================================
   // Clock, hang guard, shared tasks
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         $display("BAD %0t run hung", $time);
         summarize();
      end
   end
   task summarize();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRd <= 1'b0;
      #1 chk(regRdData, exp);
   endtask : rd
   task ack();
      @(posedge clock);
      regWr <= 1'b1;
      regAddr <= ADR_ACK;
      regWrData <= 8'h01;
      @(posedge clock);
      regWr <= 1'b0;
   endtask : ack
   task evt(input int i);
      @(posedge clock);
      faultEvt <= {{(NUM_EVT-1){1'b0}}, 1'b1} << i;
      @(posedge clock);
      faultEvt <= '0;
      #1 chk({7'h00, logValid}, {7'h00, i < EV_SAVE_CTL});
   endtask : evt
   task waitack(input logic v);
      for (int k = 0; k < 60 && xferAck !== v; k++) @(posedge clock);
      chk({7'h00, xferAck}, {7'h00, v});
   endtask : waitack

   // ==========================================================
   // Tests
   initial begin
      {xferReq, cmdSent, cmdRetry, regWr, regRd, slow, regAddr, regWrData, faultEvt} = '0;
      {ctlStatus, ctlError, ifStatus, vendorStatus} = 32'h5AC33C96;
      rst = 1'b1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      evt(0);
      rd(ADR_CODE, 8'h60);
      rd(ADR_BYTE8, 8'h5A);
      rd(ADR_BYTE9, 8'hC3);
      rd(ADR_STATUS, 8'h01);
      rd(4'hF, 8'h00);
      evt(31);
      rd(ADR_CODE, 8'h60);
      ack();
      rd(ADR_STATUS, 8'h00);
      $display("test hold done");
      for (int i = 0; i < 47; i++) begin
         evt(i);
         chk({7'h00, noRetry}, {7'h00, i == 30});
         chk({7'h00, missedSeek}, {7'h00, i == 19});
         if (i > 44) begin
            chk({7'h00, faultValid}, 8'h00);
         end else begin
            rd(ADR_CODE, EXP[i]);
            rd(ADR_BYTE8, i < 22 ? ctlStatus : i < 31 ? ifStatus : 8'h00);
            rd(ADR_BYTE9, i < 22 ? ctlError : i < 31 ? vendorStatus : 8'h00);
            rd(ADR_BYTE10, 8'h00);
            ack();
         end
      end
      $display("test codes done");
      // Head error set: a header-match failure is not a missed seek
      ctlStatus <= 8'h5B;
      evt(EV_HDR_MATCH);
      chk({7'h00, missedSeek}, 8'h00);
      rd(ADR_CODE, 8'h83);
      ack();
      $display("test head error done");
      @(posedge clock);
      slow <= 1'b1;
      xferReq <= 1'b1;
      repeat (XC + 8) @(posedge clock);
      rd(ADR_CODE, 8'hD0);
      waitack(1'b1);
      ack();
      xferReq <= 1'b0;
      repeat (XC + 8) @(posedge clock);
      rd(ADR_CODE, 8'hD1);
      waitack(1'b0);
      ack();
      slow <= 1'b0;
      xferReq <= 1'b1;
      waitack(1'b1);
      @(posedge clock);
      xferReq <= 1'b0;
      waitack(1'b0);
      cmdSent <= 1'b1;
      @(posedge clock);
      cmdSent <= 1'b0;
      repeat (CC + 8) @(posedge clock);
      #1 chk({7'h00, faultValid}, 8'h00);
      $display("test handshake done");
      @(posedge clock);
      slow <= 1'b1;
      cmdSent <= 1'b1;
      @(posedge clock);
      cmdSent <= 1'b0;
      rd(ADR_STATUS, 8'h04);
      repeat (CC + 6) @(posedge clock);
      rd(ADR_CODE, 8'hD2);
      ack();
      for (int k = 0; k <= RT; k++) begin
         if (k == RT) chk({7'h00, faultValid}, 8'h00);
         @(posedge clock);
         cmdRetry <= 1'b1;
         @(posedge clock);
         cmdRetry <= 1'b0;
         repeat (2) @(posedge clock);
      end
      rd(ADR_CODE, 8'hD3);
      rd(ADR_LOG, 8'(RT + 1));
      ack();
      $display("test command done");
      summarize();
   end
endmodule : dfr_reporter_test
